/* File: rtl/psi_pkg.sv */
// Purpose: Shared constants for the status indicator controller
// Assumes: 125 MHz core clock, word-indexed register map
// Notes: Byte address of a register is four times its index
package psi_pkg;
  // Register indices
  localparam logic [5:0] IDX_FUNC = 6'h16;
  localparam logic [5:0] IDX_TIME = 6'h18;
  localparam logic [5:0] IDX_FORCE = 6'h19;
  localparam logic [5:0] IDX_CAL = 6'h1E;
  localparam logic [5:0] IDX_TARGET = 6'h1F;
  // Reset values
  localparam logic [15:0] FUNC_RST = 16'h0000;
  localparam logic [15:0] TIME_RST = 16'h4200;
  localparam logic [15:0] FORCE_RST = 16'h0000;
  localparam logic [2:0] TARGET_RST = 3'h2;
  // Field positions
  localparam int FUNC_W = 4;
  localparam int RATE_W = 3;
  localparam int FORCE_W = 2;
  localparam int POL_LSB = 12;
  localparam int STR_LSB = 12;
  localparam int BLINK_LSB = 9;
  localparam int CAL_RESTART_BIT = 15;
  localparam int CAL_DONE_BIT = 14;
  localparam int CAL_PU_LSB = 8;
  localparam int CAL_LATCH_BIT = 6;
  localparam int CAL_SEL_BIT = 5;
  localparam int TGT_PU_LSB = 4;
  // Function codes
  localparam logic [3:0] FN_COL = 4'h0;
  localparam logic [3:0] FN_ERR = 4'h1;
  localparam logic [3:0] FN_DPX = 4'h2;
  localparam logic [3:0] FN_DPX_COL = 4'h3;
  localparam logic [3:0] FN_SPEED = 4'h4;
  localparam logic [3:0] FN_LINK = 4'h5;
  localparam logic [3:0] FN_TX = 4'h6;
  localparam logic [3:0] FN_RX = 4'h7;
  localparam logic [3:0] FN_ACT = 4'h8;
  localparam logic [3:0] FN_LINK_RX = 4'h9;
  localparam logic [3:0] FN_LINK_ACT = 4'hA;
  localparam logic [3:0] FN_ACT_BL = 4'hB;
  localparam logic [3:0] FN_TX_BL = 4'hC;
  localparam logic [3:0] FN_RX_BL = 4'hD;
  localparam logic [3:0] FN_IRQ = 4'hE;
  localparam logic [3:0] FN_OFF = 4'hF;
  // Force and rate codes
  localparam logic [1:0] FRC_NORMAL = 2'h0;
  localparam logic [1:0] FRC_BLINK = 2'h1;
  localparam logic [1:0] FRC_OFF = 2'h2;
  localparam logic [1:0] FRC_ON = 2'h3;
  localparam logic [2:0] RATE_10 = 3'h0;
  localparam logic [2:0] RATE_100 = 3'h5;
  // Timing
  localparam int CLK_MHZ = 125;
  localparam int TICK_MS = 21;
  localparam int TICK_CYC_DEF = TICK_MS * 1000 * CLK_MHZ;
  localparam int CAL_SETTLE_NS = 200;
  localparam int CAL_SETTLE_CYC = (CAL_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [4:0] CAL_CNT_LOAD = 5'(CAL_SETTLE_CYC - 1);
  localparam logic [4:0] CAL_TRIAL = 5'h10;
  localparam logic [2:0] CAL_TOP_BIT = 3'h4;
  // Stretched event slots
  localparam int EV_COL = 0;
  localparam int EV_ERR = 1;
  localparam int EV_TX = 2;
  localparam int EV_RX = 3;
  localparam int EV_ACT = 4;
  localparam int EV_N = 5;
  typedef enum logic [0:0] {CAL_IDLE, CAL_SETTLE} psi_cal_e;
endpackage

/* File: rtl/psi_stretch.sv */
// Purpose: Restartable pulse stretcher for one status event
// Assumes: tick is a one-cycle pulse from the shared time base
// Notes: len of zero passes the event through for one cycle
`timescale 1ns/100ps
module psi_stretch (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Event and timing
  input wire logic trig,
  input wire logic tick,
  input wire logic [6:0] len,
  // Stretched level
  output logic active_q
);
  typedef struct packed {
    logic [6:0] cnt;
    logic act;
  } psi_str_s;
  psi_str_s s_q;
  psi_str_s s_d;

  always_comb begin
    s_d = s_q;
    if (trig) begin
      s_d.cnt = len;
    end else if (tick && s_q.cnt != 7'h00) begin
      s_d.cnt = s_q.cnt - 7'h01;
    end
    s_d.act = trig || s_d.cnt != 7'h00;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign active_q = s_q.act;

  stretch_hold_a: assert property (@(posedge clk) disable iff (rst)
    trig && len > 7'h01 |=> active_q [*2])
    else $error("stretched event dropped too early");
endmodule

/* File: rtl/psi_indicator_ctrl.sv */
// Purpose: Drive three status indicator pins and the MAC pad calibration
// Assumes: Status inputs come from the PHY core on clk; comparator
//   inputs are analog and asynchronous
// Notes: Classic Wishbone slave, 32-bit data, registers in low 16 bits
// Operation
// - Each indicator picks status control or software forcing on its own.
// - Two-bit force field: normal, blink, forced inactive, forced active.
// - With force normal, a four-bit function field selects the status.
// - Codes 0 to 10 pick collision through link-or-activity; codes 8 and 9 stay off on indicator a.
// - Codes 11 to 13 blink activity, transmit, receive; code 15 off.
// - Code 14 shows interrupt on indicator c, blinking collision elsewhere.
// - Speed function qualified per indicator: 10 Mb, 100 Mb or off.
// - Polarity bit per indicator sets the active pin level, in all modes.
// - Short events are stretched by a shared programmable duration.
// - A shared field sets the blink period for every blinking output.
// - Status-driven indicators follow the present PHY state.
// - Pad calibration runs automatically after reset at default target.
// - Software may change the target and restart calibration.
// - Manual pull-up and pull-down strengths may replace the result.
// - Restart bit self-clears then calibration starts; done flag reads.
// - Latch bit loads a manual value into the selected strength.
`timescale 1ns/100ps
module psi_indicator_ctrl import psi_pkg::*; #(
  parameter int TICK_CYC = TICK_CYC_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // PHY status
  input wire logic link_up,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic collision_status,
  input wire logic error_event,
  input wire logic tx_event,
  input wire logic rx_event,
  input wire logic irq_status,
  // Indicator pins, c is bit 2
  output logic [2:0] ind_pins,
  // Pad calibration
  input wire logic pu_weak,
  input wire logic pd_weak,
  output logic [4:0] pu_strength,
  output logic [4:0] pd_strength,
  output logic [2:0] pu_target,
  output logic [2:0] pd_target,
  output logic cal_done
);
  typedef struct packed {
    logic [15:0] func;
    logic [15:0] timing;
    logic [15:0] force_pol;
    logic [2:0] pu_tgt;
    logic [2:0] pd_tgt;
    logic ack;
    logic [31:0] rdat;
    logic [21:0] tick_cnt;
    logic [7:0] blink_cnt;
    logic blink_ph;
    logic [2:0] pins;
    psi_cal_e cal_st;
    logic [2:0] cal_bit;
    logic [4:0] cal_cnt;
    logic cal_restart;
    logic cal_sel;
    logic done;
    logic [4:0] pu;
    logic [4:0] pd;
    logic pu_s1;
    logic pu_s2;
    logic pd_s1;
    logic pd_s2;
  } psi_state_s;

  // Pins rest at the inactive level of the reset polarity, not lit
  localparam psi_state_s RST_STATE = '{
    func: FUNC_RST, timing: TIME_RST, force_pol: FORCE_RST,
    pu_tgt: TARGET_RST, pd_tgt: TARGET_RST, ack: 1'b0,
    rdat: 32'h0000_0000, tick_cnt: 22'h0, blink_cnt: 8'h00,
    blink_ph: 1'b0, pins: ~FORCE_RST[POL_LSB +: 3], cal_st: CAL_SETTLE,
    cal_bit: CAL_TOP_BIT, cal_cnt: CAL_CNT_LOAD, cal_restart: 1'b0,
    cal_sel: 1'b0, done: 1'b0, pu: CAL_TRIAL, pd: CAL_TRIAL,
    pu_s1: 1'b0, pu_s2: 1'b0, pd_s1: 1'b0, pd_s2: 1'b0};
  localparam logic [21:0] TICK_LAST = 22'(TICK_CYC - 1);

  psi_state_s s_q;
  psi_state_s s_d;
  logic acc;
  logic wr;
  logic tick;
  logic [5:0] idx;
  logic [15:0] wd;
  logic [EV_N-1:0] ev_trig;
  logic [EV_N-1:0] ev_str;
  logic [6:0] str_len;

  // Byte-lane merge of a write into a 16-bit register
  function automatic logic [15:0] wmerge(input logic [15:0] old,
      input logic [15:0] dat, input logic [1:0] sel);
    wmerge = old;
    if (sel[0]) begin
      wmerge[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      wmerge[15:8] = dat[15:8];
    end
  endfunction

  // Stretch length in ticks; the extra tick covers tick phase
  function automatic logic [6:0] stretch_len(input logic [2:0] code);
    if (code == 3'h0) begin
      stretch_len = 7'h00;
    end else begin
      stretch_len = (7'h01 << (code - 3'h1)) + 7'h01;
    end
  endfunction

  // Status selected by one indicator's function and rate fields
  function automatic logic ind_active(input logic [3:0] fn,
      input logic [2:0] rate, input int unsigned n,
      input logic [EV_N-1:0] st, input logic lnk, input logic spd,
      input logic fdx, input logic irq, input logic ph);
    logic sp;
    sp = 1'b0;
    if (rate == RATE_10) begin
      sp = lnk && !spd;
    end else if (rate == RATE_100) begin
      sp = lnk && spd;
    end
    case (fn)
      FN_COL: ind_active = st[EV_COL];
      FN_ERR: ind_active = st[EV_ERR];
      FN_DPX: ind_active = fdx;
      FN_DPX_COL: ind_active = fdx || st[EV_COL];
      FN_SPEED: ind_active = sp;
      FN_LINK: ind_active = lnk;
      FN_TX: ind_active = st[EV_TX];
      FN_RX: ind_active = st[EV_RX];
      FN_ACT: ind_active = n != 0 && st[EV_ACT];
      FN_LINK_RX: ind_active = n != 0 && (lnk || st[EV_RX]);
      FN_LINK_ACT: ind_active = lnk || st[EV_ACT];
      FN_ACT_BL: ind_active = st[EV_ACT] && ph;
      FN_TX_BL: ind_active = st[EV_TX] && ph;
      FN_RX_BL: ind_active = st[EV_RX] && ph;
      FN_IRQ: ind_active = n == 2 ? irq : st[EV_COL] && ph;
      default: ind_active = 1'b0;
    endcase
  endfunction

  assign acc = wb_cyc_i && wb_stb_i && !s_q.ack;
  assign wr = acc && wb_we_i;
  assign idx = wb_adr_i[7:2];
  assign wd = wb_dat_i[15:0];
  assign tick = s_q.tick_cnt == TICK_LAST;
  assign str_len = stretch_len(s_q.timing[STR_LSB +: 3]);
  assign ev_trig = {tx_event || rx_event, rx_event, tx_event,
    error_event, collision_status};

  // Shared stretch timers, one per event kind
  for (genvar g = 0; g < EV_N; g++) begin : g_str
    psi_stretch u_str (
      .clk(clk),
      .rst(rst),
      .trig(ev_trig[g]),
      .tick(tick),
      .len(str_len),
      .active_q(ev_str[g])
    );
  end

  always_comb begin
    logic a;
    logic [1:0] fsel;
    logic [7:0] half;
    a = 1'b0;
    fsel = FRC_NORMAL;
    half = 8'h01 << s_q.timing[BLINK_LSB +: 3];
    s_d = s_q;
    s_d.ack = acc;
    s_d.pu_s1 = pu_weak;
    s_d.pu_s2 = s_q.pu_s1;
    s_d.pd_s1 = pd_weak;
    s_d.pd_s2 = s_q.pd_s1;

    // Free-running time base and blink phase
    s_d.tick_cnt = tick ? 22'h0 : s_q.tick_cnt + 22'h1;
    if (tick) begin
      if (s_q.blink_cnt >= half - 8'h01) begin
        s_d.blink_cnt = 8'h00;
        s_d.blink_ph = !s_q.blink_ph;
      end else begin
        s_d.blink_cnt = s_q.blink_cnt + 8'h01;
      end
    end

    // Indicator pins, recomputed every cycle from live status
    for (int i = 0; i < 3; i++) begin
      fsel = s_q.force_pol[FORCE_W*i +: FORCE_W];
      case (fsel)
        FRC_NORMAL: a = ind_active(s_q.func[FUNC_W*i +: FUNC_W],
          s_q.timing[RATE_W*i +: RATE_W], i, ev_str, link_up,
          speed_100, full_duplex, irq_status, s_q.blink_ph);
        FRC_BLINK: a = s_q.blink_ph;
        FRC_OFF: a = 1'b0;
        default: a = 1'b1;
      endcase
      s_d.pins[i] = s_q.force_pol[POL_LSB+i] ? a : !a;
    end

    // Successive approximation, both drivers in parallel
    s_d.cal_restart = 1'b0;
    if (s_q.cal_restart) begin
      s_d.cal_st = CAL_SETTLE;
      s_d.cal_bit = CAL_TOP_BIT;
      s_d.cal_cnt = CAL_CNT_LOAD;
      s_d.pu = CAL_TRIAL;
      s_d.pd = CAL_TRIAL;
      s_d.done = 1'b0;
    end else begin
      case (s_q.cal_st)
        CAL_SETTLE: begin
          if (s_q.cal_cnt != 5'h00) begin
            s_d.cal_cnt = s_q.cal_cnt - 5'h01;
          end else begin
            // Strong enough already: drop the trial finger
            if (!s_q.pu_s2) begin
              s_d.pu[s_q.cal_bit] = 1'b0;
            end
            if (!s_q.pd_s2) begin
              s_d.pd[s_q.cal_bit] = 1'b0;
            end
            if (s_q.cal_bit == 3'h0) begin
              s_d.cal_st = CAL_IDLE;
              s_d.done = 1'b1;
            end else begin
              s_d.cal_bit = s_q.cal_bit - 3'h1;
              s_d.pu[s_q.cal_bit - 3'h1] = 1'b1;
              s_d.pd[s_q.cal_bit - 3'h1] = 1'b1;
              s_d.cal_cnt = CAL_CNT_LOAD;
            end
          end
        end
        default: s_d.cal_st = CAL_IDLE;
      endcase
    end

    // Register writes
    if (wr) begin
      if (idx == IDX_FUNC) begin
        s_d.func = wmerge(s_q.func, wd, wb_sel_i[1:0]);
      end else if (idx == IDX_TIME) begin
        s_d.timing = wmerge(s_q.timing, wd, wb_sel_i[1:0]);
      end else if (idx == IDX_FORCE) begin
        s_d.force_pol = wmerge(s_q.force_pol, wd, wb_sel_i[1:0]);
      end else if (idx == IDX_TARGET && wb_sel_i[0]) begin
        s_d.pu_tgt = wd[TGT_PU_LSB +: 3];
        s_d.pd_tgt = wd[2:0];
      end else if (idx == IDX_CAL) begin
        if (wb_sel_i[1]) begin
          s_d.cal_restart = wd[CAL_RESTART_BIT];
        end
        if (wb_sel_i[0]) begin
          s_d.cal_sel = wd[CAL_SEL_BIT];
        end
        // Manual latch aborts any calibration in flight
        if (wb_sel_i[0] && wd[CAL_LATCH_BIT] && !s_d.cal_restart) begin
          s_d.cal_st = CAL_IDLE;
          s_d.done = 1'b1;
          if (wd[CAL_SEL_BIT]) begin
            s_d.pu = wd[CAL_PU_LSB +: 5];
          end else begin
            s_d.pd = wd[4:0];
          end
        end
      end
    end

    // Register reads; unmapped reads return zero
    if (acc && !wb_we_i) begin
      s_d.rdat = 32'h0000_0000;
      if (idx == IDX_FUNC) begin
        s_d.rdat[15:0] = s_q.func;
      end else if (idx == IDX_TIME) begin
        s_d.rdat[15:0] = s_q.timing;
      end else if (idx == IDX_FORCE) begin
        s_d.rdat[15:0] = s_q.force_pol;
      end else if (idx == IDX_TARGET) begin
        s_d.rdat[TGT_PU_LSB +: 3] = s_q.pu_tgt;
        s_d.rdat[2:0] = s_q.pd_tgt;
      end else if (idx == IDX_CAL) begin
        s_d.rdat[CAL_RESTART_BIT] = s_q.cal_restart;
        s_d.rdat[CAL_DONE_BIT] = s_q.done;
        s_d.rdat[CAL_PU_LSB +: 5] = s_q.pu;
        s_d.rdat[CAL_SEL_BIT] = s_q.cal_sel;
        s_d.rdat[4:0] = s_q.pd;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdat;
  assign ind_pins = s_q.pins;
  assign pu_strength = s_q.pu;
  assign pd_strength = s_q.pd;
  assign pu_target = s_q.pu_tgt;
  assign pd_target = s_q.pd_tgt;
  assign cal_done = s_q.done;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");
  force_on_a: assert property (
    s_q.force_pol[1:0] == FRC_ON |=>
      ind_pins[0] == $past(s_q.force_pol[POL_LSB]))
    else $error("forced-on indicator a at wrong level");
  force_off_a: assert property (
    s_q.force_pol[5:4] == FRC_OFF |=>
      ind_pins[2] != $past(s_q.force_pol[POL_LSB+2]))
    else $error("forced-off indicator c at wrong level");
  func_off_a: assert property (
    s_q.force_pol[3:2] == FRC_NORMAL && s_q.func[7:4] == FN_OFF |=>
      ind_pins[1] != $past(s_q.force_pol[POL_LSB+1]))
    else $error("function off did not hold b inactive");
  link_follow_a: assert property (
    s_q.force_pol[1:0] == FRC_NORMAL && s_q.func[3:0] == FN_LINK |=>
      ind_pins[0] == ($past(link_up) ~^ $past(s_q.force_pol[POL_LSB])))
    else $error("indicator a does not follow link");
  speed_off_a: assert property (
    s_q.force_pol[3:2] == FRC_NORMAL && s_q.func[7:4] == FN_SPEED
      && s_q.timing[5:3] == 3'h6 |=>
      ind_pins[1] != $past(s_q.force_pol[POL_LSB+1]))
    else $error("speed select off did not hold b inactive");
  restart_sc_a: assert property (
    s_q.cal_restart |=> !s_q.cal_restart && s_q.cal_st == CAL_SETTLE
      && !cal_done)
    else $error("restart did not self clear and start");
  cal_busy_a: assert property (
    s_q.cal_st == CAL_SETTLE |-> !cal_done)
    else $error("done flag set while calibrating");
  latch_load_a: assert property (
    wr && idx == IDX_CAL && wb_sel_i[1:0] == 2'h3 && wd[CAL_LATCH_BIT]
      && wd[CAL_SEL_BIT] && !wd[CAL_RESTART_BIT] |=>
      pu_strength == $past(wd[CAL_PU_LSB +: 5]) && cal_done)
    else $error("latch did not load pull-up strength");
  cal_len_a: assert property (
    $rose(s_q.cal_st == CAL_SETTLE) && !s_q.cal_restart
      |-> ##[1:200] cal_done || s_q.cal_restart)
    else $error("calibration did not finish in time");
endmodule

/* File: verif/psi_board_model.sv */
// Purpose: Board lamps on the indicator pins and pad comparators
// Assumes: Wiring polarity of each lamp is set by the bench
// Notes: Comparator threshold scales with the target code
`timescale 1ns/100ps
module psi_board_model (
  // Indicator side
  input wire logic [2:0] ind_pins,
  input wire logic [2:0] act_hi,
  output logic [2:0] lit,
  // Pad side
  input wire logic [4:0] pu_strength,
  input wire logic [4:0] pd_strength,
  input wire logic [2:0] pu_target,
  input wire logic [2:0] pd_target,
  output logic pu_weak,
  output logic pd_weak
);
  // A lamp lights only at its wired active level
  assign lit = ~(ind_pins ^ act_hi);
  // Too few fingers for the target reads as weak, so SAR ends at thr-1
  assign pu_weak = pu_strength < {pu_target, 2'b00};
  assign pd_weak = pd_strength < {pd_target, 2'b00};
endmodule

/* File: verif/phy_status_indicator_control_tb.sv */
// Purpose: Self-checking bench for the status indicator controller
// Assumes: Short tick of four cycles to keep the run brief
// Notes: Level cases come from a table, timed cases follow it
`timescale 1ns/100ps
module phy_status_indicator_control_tb import psi_pkg::*;;
  localparam int TK = 4;
  `define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    miscompares++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
  typedef struct packed {
    logic [15:0] f, t, p;
    logic [3:0] s;
    logic [2:0] a;
  } psi_row_s;
  logic clk, rst, cyc, stb, we, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, rdat, q;
  logic lnk, spd, fdx, col, err, tx, rx, irq, puw, pdw, done;
  logic [2:0] pins, lit, hi, put, pdt;
  logic [4:0] pus, pds;
  int miscompares, cmp_count, n;
  psi_row_s rows[12] = '{
    '{16'h0000, 16'h4200, 16'h003F, 4'h0, 3'b111},
    '{16'h0000, 16'h4200, 16'h703F, 4'h0, 3'b111},
    '{16'h0000, 16'h4200, 16'h702A, 4'h0, 3'b000},
    '{16'h0500, 16'h4200, 16'h700B, 4'h1, 3'b101},
    '{16'h0452, 16'h4200, 16'h7000, 4'h5, 3'b111},
    '{16'h0452, 16'h4200, 16'h7000, 4'h7, 3'b011},
    '{16'h0452, 16'h4340, 16'h7000, 4'h7, 3'b111},
    '{16'h0452, 16'h4380, 16'h7000, 4'h7, 3'b011},
    '{16'h0A98, 16'h4200, 16'h7000, 4'h1, 3'b110},
    '{16'h0EF3, 16'h4200, 16'h7000, 4'hC, 3'b101},
    '{16'h0555, 16'h4200, 16'h0000, 4'h1, 3'b111},
    '{16'h0555, 16'h4200, 16'h0000, 4'h0, 3'b000}};
  psi_indicator_ctrl #(.TICK_CYC(TK)) u_psi_indicator_ctrl (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_ack_o(ack), .wb_dat_o(rdat), .link_up(lnk), .speed_100(spd),
    .full_duplex(fdx), .collision_status(col), .error_event(err),
    .tx_event(tx), .rx_event(rx), .irq_status(irq), .ind_pins(pins),
    .pu_weak(puw), .pd_weak(pdw), .pu_strength(pus),
    .pd_strength(pds), .pu_target(put), .pd_target(pdt),
    .cal_done(done));
  psi_board_model u_psi_board_model (
    .ind_pins(pins), .act_hi(hi), .lit(lit), .pu_strength(pus),
    .pd_strength(pds), .pu_target(put), .pd_target(pdt),
    .pu_weak(puw), .pd_weak(pdw));
  task automatic end_sim();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [5:0] i,
                    input logic [15:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    dat <= {16'h0000, d};
    sel <= 4'h3;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (k >= 20) miscompares++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // Cycles until pin a changes, bounded
  task automatic edge_a();
    logic p;
    p = pins[0];
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (pins[0] === p && n < 200);
  endtask
  task automatic cal_wait(input logic [4:0] e);
    n = 0;
    while (done !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    `CHK("cal_done", 1'b1, done)
    `CHK("pu_strength", e, pus)
    `CHK("pd_strength", e, pds)
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim();
  end
  initial begin
    {cyc, stb, we, adr, sel, dat} = '0;
    {lnk, spd, fdx, col, err, tx, rx, irq} = '0;
    hi = 3'b000;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK("cal_done_rst", 1'b0, done)
    `CHK("pins_rst", 3'b111, pins)
    `CHK("tgt_rst", 6'o22, {put, pdt})
    wb(0, IDX_FUNC, 0);
    `CHK("func_rst", 32'(FUNC_RST), q)
    wb(0, IDX_TIME, 0);
    `CHK("time_rst", 32'h0000_4200, q)
    wb(0, IDX_FORCE, 0);
    `CHK("force_rst", 32'(FORCE_RST), q)
    wb(1, 6'h01, 16'hFFFF);
    wb(0, 6'h01, 0);
    `CHK("unmapped", 32'h0, q)
    cal_wait(5'h07);
    // Level cases
    foreach (rows[r]) begin
      wb(1, IDX_FUNC, rows[r].f);
      wb(1, IDX_TIME, rows[r].t);
      wb(1, IDX_FORCE, rows[r].p);
      {irq, fdx, spd, lnk} <= rows[r].s;
      hi = rows[r].p[14:12];
      repeat (3) @(negedge clk);
      `CHK("lamps", rows[r].a, lit)
    end
    wb(0, IDX_FUNC, 0);
    `CHK("func_rw", 32'h0000_0555, q)
    // Stretched events behind the function codes
    wb(1, IDX_FUNC, 16'h0180);
    {rx, err} <= 2'b11;
    repeat (3) @(negedge clk);
    `CHK("events", 3'b110, lit)
    {rx, err} <= 2'b00;
    // Stretch restarts on a second event
    wb(1, IDX_FUNC, 16'h0006);
    wb(1, IDX_TIME, 16'h4200);
    wb(1, IDX_FORCE, 16'h1000);
    hi = 3'b001;
    for (int e = 0; e < 2; e++) begin
      @(posedge clk);
      tx <= 1'b1;
      @(posedge clk);
      tx <= 1'b0;
      repeat (18) @(posedge clk);
    end
    @(negedge clk);
    `CHK("stretch_on", 1'b1, pins[0])
    repeat (10) @(negedge clk);
    `CHK("stretch_hold", 1'b1, pins[0])
    edge_a();
    `CHK("stretch_end", 1'b1, n <= 15)
    // Blink half periods: forced, transmit blink, collision blink
    for (int c = 0; c < 3; c++) begin
      wb(1, IDX_TIME, 16'h4000 | (16'(c) << 9));
      wb(1, IDX_FUNC, c == 0 ? 16'h0000 : (c == 1 ? 16'h000C : 16'h000E));
      wb(1, IDX_FORCE, c == 0 ? 16'h1001 : 16'h1000);
      tx <= (c == 1);
      col <= (c == 2);
      // Let the stretched event reach the pin before timing edges
      repeat (4) @(negedge clk);
      edge_a();
      edge_a();
      `CHK("blink_hi", (1 << c) * TK, n)
      edge_a();
      `CHK("blink_lo", (1 << c) * TK, n)
    end
    tx <= 1'b0;
    col <= 1'b0;
    // New target and restart
    wb(1, IDX_TARGET, 16'h0033);
    `CHK("targets", 6'o33, {put, pdt})
    wb(1, IDX_CAL, 16'h8000);
    wb(0, IDX_CAL, 0);
    `CHK("restart_clr", 2'b00, q[15:14])
    cal_wait(5'h0B);
    wb(0, IDX_CAL, 0);
    `CHK("cal_reg", {1'b1, 1'b0, 5'h0B, 3'b000, 5'h0B}, q[14:0])
    // Manual latch into each strength
    wb(1, IDX_CAL, 16'h1560);
    @(negedge clk);
    `CHK("pu_manual", 5'h15, pus)
    wb(1, IDX_CAL, 16'h0049);
    @(negedge clk);
    `CHK("pd_manual", 7'h55, {pus, pds[4:3]})
    `CHK("pd_low", 3'h1, pds[2:0])
    wb(0, IDX_CAL, 0);
    `CHK("latch_rd", 2'b01, {q[6], q[14]})
    // Reset in mid-run restores defaults and reruns calibration
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK("rerst_done", 1'b0, done)
    `CHK("rerst_pins", 3'b111, pins)
    `CHK("rerst_pu", 5'h10, pus)
    wb(0, IDX_FORCE, 0);
    `CHK("rerst_force", 32'(FORCE_RST), q)
    cal_wait(5'h07);
    end_sim();
  end
endmodule
